// ===== dv/ditc_far.sv
`timescale 1ns/100ps
// Far side: pulse source on both pins, logger ending each scan
module ditc_far (
  input  wire logic  core_clk,
  input  wire logic  acq_start,
  input  wire logic  slow,
  output logic       acq_done,
  output logic [1:0] pins
);
  logic [3:0] pend = 4'h0;
  initial acq_done = 1'b0;
  initial pins = 2'h0;
  // Scan ends one or four cycles after it starts
  always @(posedge core_clk) begin
    pend <= #1 {pend[2:0], acq_start};
    acq_done <= #1 slow ? pend[2] : acq_start;
  end
  task automatic set_pin(input int i, input logic v);
    @(posedge core_clk);
    pins[i] <= #1 v;
  endtask
endmodule // ditc_far

// ===== dv/ditc_top_monitor.sv
`timescale 1ns/100ps
module ditc_top_monitor
  import ditc_pkg::*;
#(parameter int NUM_IN = DITC_NUM_IN) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [NUM_IN-1:0] indexed_digital_input,
  input wire ditc_cfg_s         cfg [NUM_IN],
  input wire logic              acq_done,
  input wire logic              acq_start,
  input wire logic              acq_store,
  input wire logic              acq_trig,
  input wire ditc_gauge_s       gauge [NUM_IN],
  input wire logic              low_power_block,
  input wire logic              trig_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Any input enabled; first input armed for a rising trigger
  wire en = cfg[0].mode != DITC_MODE_DISABLED || cfg[1].mode != 2'h0;
  wire arm = cfg[0].mode == DITC_MODE_TRIGGER && cfg[0].edge_sel == 1'b0
    && cfg[0].readings != 8'h00 && !trig_busy;
  a_trig_marks_start: assert property (
    acq_trig == acq_start) else $error("trig flag");
  a_store_after_done: assert property (
    acq_store |-> $past(acq_done)) else $error("store");
  a_start_single: assert property (
    acq_start |-> trig_busy ##1 !acq_start) else $error("start");
  a_edge_starts_scan: assert property (
    $rose(indexed_digital_input[0]) && arm |-> ##[1:5] acq_start)
    else $error("no start");
  a_enable_blocks_sleep: assert property (
    1 |=> low_power_block == $past(en)) else $error("sleep");
  a_gauge_scaled: assert property (
    gauge[1].valid |-> gauge[1].scaled == gauge[1].raw * cfg[1].sens)
    else $error("scale");
  a_gauge_rate_gap: assert property (
    gauge[1].valid && cfg[1].rate == 24'h4 |=> !gauge[1].valid [*4])
    else $error("rate");
  a_gauge_mode_off: assert property (
    cfg[1].mode inside {2'h0, 2'h1} |=> !gauge[1].valid) else $error("off");
  c_store: cover property (acq_store);
  c_gauge: cover property (gauge[1].valid);
  c_next_scan: cover property (acq_start && $past(acq_done));
endmodule // ditc_top_monitor
bind ditc_top ditc_top_monitor #(.NUM_IN(NUM_IN)) mon (.*);

// ===== dv/ditc_top_tb.sv
`timescale 1ns/100ps
module ditc_top_tb;
  import ditc_pkg::*;
  logic        core_clk = 0;
  logic        rst = 1;
  logic        slow = 0;
  logic acq_done, acq_start, acq_store, acq_trig, low_power_block, trig_busy;
  logic [1:0]  pins;
  ditc_cfg_s   cfg [2];
  ditc_gauge_s gauge [2];
  int miscompares = 0, n_checks = 0, n_start = 0, n_store = 0, n_val, cyc = 0;
  always #10 core_clk = ~core_clk;
  ditc_far far (.core_clk, .acq_start, .slow, .acq_done, .pins);
  ditc_top dut (.core_clk, .rst, .indexed_digital_input(pins), .cfg,
    .acq_done, .acq_start, .acq_store, .acq_trig, .gauge, .low_power_block,
    .trig_busy);
  // Count scans and stores; cut a hang short
  always @(posedge core_clk) begin
    n_start += acq_start;
    n_store += acq_store;
    if (++cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h", $time, m, got);
    end
  endtask
  task automatic set_cfg(input int i, input ditc_mode_e m, input ditc_edge_e e,
    input logic [7:0] n);
    @(posedge core_clk);
    cfg[i] <= #1 '{m, e, 24'h4, 16'h3, n};
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cfg[0] = '0;
    cfg[1] = '0;
    repeat (20) @(posedge core_clk);
    rst <= #1 1'b0;
    repeat (3) @(posedge core_clk);
    check(low_power_block, 0, "idle sleep");
    // Burst of three on a slow logger; a mid-burst edge is refused
    set_cfg(0, DITC_MODE_TRIGGER, DITC_EDGE_RISING, 8'h3);
    slow <= #1 1'b1;
    far.set_pin(0, 1);
    repeat (6) @(posedge core_clk);
    far.set_pin(0, 0);
    far.set_pin(0, 1);
    repeat (30) @(posedge core_clk);
    check(n_start, 3, "burst");
    check(n_store, 3, "stores");
    check(low_power_block, 1, "sleep");
    // Falling edge chosen: only the high-to-low change scans
    set_cfg(0, DITC_MODE_TRIGGER, DITC_EDGE_FALLING, 8'h1);
    slow <= #1 1'b0;
    far.set_pin(0, 0);
    repeat (10) @(posedge core_clk);
    check(n_start, 4, "fall");
    far.set_pin(0, 1);
    repeat (10) @(posedge core_clk);
    check(n_start, 4, "rise");
    // Both gauge modes: two or three pulses per five-cycle window
    set_cfg(0, DITC_MODE_DISABLED, DITC_EDGE_RISING, 8'h0);
    for (int m = 2; m < 4; m++) begin
      set_cfg(1, ditc_mode_e'(m), DITC_EDGE_RISING, 8'h0);
      n_val = 0;
      repeat (34) begin
        far.set_pin(1, ~pins[1]);
        #2;
        if (gauge[1].valid === 1'b1 && ++n_val > 1)
          check(gauge[1].scaled inside {6, 9}, 1, "scaled");
      end
      check(n_val > 4, 1, "windows");
    end
    set_cfg(1, DITC_MODE_DISABLED, DITC_EDGE_RISING, 8'h0);
    repeat (3) @(posedge core_clk);
    check(low_power_block, 0, "sleep off");
    summarize();
  end
endmodule // ditc_top_tb

// ===== hdl/ditc_pkg.sv
package ditc_pkg;

  // Number of digital inputs
  localparam int DITC_NUM_IN = 2;

  // Input mode encodings
  typedef enum logic [1:0] {
    DITC_MODE_DISABLED,
    DITC_MODE_TRIGGER,
    DITC_MODE_RAIN,
    DITC_MODE_WIND
  } ditc_mode_e;

  // Edge choice for trigger mode
  typedef enum logic {
    DITC_EDGE_RISING,
    DITC_EDGE_FALLING
  } ditc_edge_e;

  // Widths
  localparam int DITC_CNT_W   = 16;
  localparam int DITC_SENS_W  = 16;
  localparam int DITC_RATE_W  = 24;
  localparam int DITC_READ_W  = 8;
  localparam int DITC_VAL_W   = DITC_CNT_W + DITC_SENS_W;

  // Reset values
  localparam logic [DITC_CNT_W-1:0]  DITC_CNT_RST   = 16'h0000;
  localparam logic [DITC_RATE_W-1:0] DITC_RATE_RST  = 24'h000000;
  localparam logic [DITC_READ_W-1:0] DITC_READ_RST  = 8'h00;
  localparam logic [1:0]             DITC_SYNC_RST  = 2'h0;

  // Per-input configuration
  typedef struct packed {
    ditc_mode_e              mode;
    ditc_edge_e              edge_sel;
    logic [DITC_RATE_W-1:0]  rate;
    logic [DITC_SENS_W-1:0]  sens;
    logic [DITC_READ_W-1:0]  readings;
  } ditc_cfg_s;

  // Gauge result towards the data store
  typedef struct packed {
    logic                    valid;
    logic [DITC_CNT_W-1:0]   raw;
    logic [DITC_VAL_W-1:0]   scaled;
  } ditc_gauge_s;

endpackage

// ===== hdl/ditc_top.sv
`timescale 1ns/100ps
// Overview of operation
// R1 - Each input has a mode: disabled, trigger, rain or wind gauge.
// R2 - Gauge modes sample the accumulated count at the per-input rate.
// R3 - Gauge modes multiply raw count by sensitivity into engineering units.
// R4 - Trigger mode edge setting picks rising or falling transition.
// R5 - Each trigger edge runs the programmed number of back-to-back reads. The code drops edges that arrive while a burst runs.
// R6 - Trigger reads run at once, ignoring the periodic interval timer.
// R7 - Trigger read results go to the data store like periodic samples.
// R8 - Every trigger read samples all configured channels.
// R9 - Any enabled input keeps acquisition on and blocks low power.
// R10 - Inputs pass a two-stage synchroniser before edge detection.
module ditc_top
  import ditc_pkg::*;
#(
  parameter int NUM_IN = DITC_NUM_IN
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [NUM_IN-1:0]      indexed_digital_input,
  input  wire ditc_cfg_s              cfg [NUM_IN],
  input  wire logic                   acq_done,
  output logic                        acq_start,
  output logic                        acq_store,
  output logic                        acq_trig,
  output ditc_gauge_s                 gauge [NUM_IN],
  output logic                        low_power_block,
  output logic                        trig_busy
);

  // Elaboration check: the selection loop and the power hold are sized
  // for one to eight inputs; anything else has no sensible meaning here
  if (NUM_IN < 1 || NUM_IN > 8) begin : g_chk
    $error("NUM_IN must be 1 to 8");
  end

  // Burst sequencer states: IDLE waits for an armed edge, RUN asks the
  // logger for one scan of every configured channel, WAIT holds until
  // the logger reports that scan finished
  typedef enum {ST_IDLE, ST_RUN, ST_WAIT} ditc_state_e;

  // Gauge decode, used per input
  function automatic logic is_gauge(input ditc_mode_e m);
    return (m == DITC_MODE_RAIN) || (m == DITC_MODE_WIND);
  endfunction

  logic [NUM_IN-1:0] trig_edge;
  logic [NUM_IN-1:0] enabled;
  logic [DITC_READ_W-1:0] trig_reads [NUM_IN];

  // Start-up guard, three cycles long: two synchroniser stages plus the
  // edge history. Until it fills, the history may hold reset values
  // rather than pin samples, and a pin that idles high would otherwise
  // look like a rising edge right after reset.
  localparam int WARM_W = 3;
  logic [WARM_W-1:0] warm;
  wire               edges_ok;

  assign edges_ok = warm[WARM_W-1];

  // Guard shift register, filled with ones after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      warm <= '0;
    end else begin
      warm <= {warm[WARM_W-2:0], 1'b1}; // see R10
    end
  end

  // One slice per input: synchroniser, edge history, mode decode and
  // the gauge counter. Slices share nothing but the start-up guard, so
  // a pin on one input can never disturb the count of another.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic [1:0]             sync;
      logic                   prev;
      logic [DITC_CNT_W-1:0]  count;
      logic [DITC_RATE_W-1:0] tick;
      wire                    in_s    = sync[1];
      wire                    rise    = in_s & ~prev & edges_ok;
      wire                    fall    = ~in_s & prev & edges_ok;
      wire                    gmode   = is_gauge(cfg[gi].mode);
      wire                    tmode   = cfg[gi].mode == DITC_MODE_TRIGGER;
      wire                    tick_hit = tick >= cfg[gi].rate;
      wire                    pulse   = gmode & rise;

      // Mode decode
      assign enabled[gi]    = cfg[gi].mode != DITC_MODE_DISABLED; // see R1
      assign trig_edge[gi]  = tmode & ((cfg[gi].edge_sel == DITC_EDGE_RISING)
                              ? rise : fall); // see R4
      assign trig_reads[gi] = cfg[gi].readings;

      // Two-stage synchroniser then edge history. Only the second stage
      // is read by logic; the first may still be settling from a pin
      // that changed right at the clock edge.
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sync <= DITC_SYNC_RST;
          prev <= 1'b0;
        end else begin
          sync <= {sync[0], indexed_digital_input[gi]}; // see R10
          prev <= sync[1]; // see R10
        end
      end

      // Pulse accumulation and periodic sampling. A window lasts rate+1
      // cycles; the pulse that lands on the closing cycle opens the next
      // window instead of being lost. Leaving gauge mode clears the
      // counter, the timer and the result, so a re-enabled gauge starts
      // from an empty window.
      always_ff @(posedge core_clk) begin
        if (rst || !gmode) begin
          count       <= DITC_CNT_RST;
          tick        <= DITC_RATE_RST;
          gauge[gi]   <= '0;
        end else if (tick_hit) begin
          tick              <= DITC_RATE_RST; // see R2
          count             <= {{(DITC_CNT_W-1){1'b0}}, pulse};
          gauge[gi].valid   <= 1'b1; // see R2
          gauge[gi].raw     <= count;
          gauge[gi].scaled  <= count * cfg[gi].sens; // see R3
        end else begin
          tick            <= tick + 1'b1;
          count           <= count + {{(DITC_CNT_W-1){1'b0}}, pulse};
          gauge[gi].valid <= 1'b0;
        end
      end
    end
  endgenerate

  // Pick the lowest triggering input and its readings count. Same-cycle
  // edges on several inputs start one burst only, sized by the lowest
  // index, since every scan covers all channels anyway.
  logic                   any_trig;
  logic [DITC_READ_W-1:0] sel_reads;
  always_comb begin
    any_trig  = 1'b0;
    sel_reads = DITC_READ_RST;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (trig_edge[i]) begin
        any_trig  = 1'b1;
        sel_reads = trig_reads[i];
      end
    end
  end

  ditc_state_e            state;
  ditc_state_e            next_state;
  logic [DITC_READ_W-1:0] remain;
  logic [DITC_READ_W-1:0] next_remain;

  // Burst control terms: a burst starts only from idle with a non-zero
  // readings count; a scan ends when the logger answers in WAIT, and
  // the last scan of a burst is the one that sees a count of one
  wire burst_go;
  wire scan_end;
  wire last_scan;

  assign burst_go  = any_trig && (sel_reads != DITC_READ_RST);
  assign scan_end  = (state == ST_WAIT) && acq_done;
  assign last_scan = remain == 8'h01;

  // Burst sequencer, free of the interval timer. Edges that arrive
  // while a burst runs are dropped on purpose: a second burst on top
  // of the first would only repeat scans the logger is already doing.
  always_comb begin
    next_state  = state;
    next_remain = remain;
    case (state)
      ST_IDLE: begin
        if (burst_go) begin
          next_state  = ST_RUN; // see R5
          next_remain = sel_reads; // see R6
        end
      end
      ST_RUN: begin
        next_state = ST_WAIT; // see R8
      end
      ST_WAIT: begin
        if (acq_done) begin
          next_remain = remain - 1'b1; // see R5
          next_state  = last_scan ? ST_IDLE : ST_RUN;
        end
      end
      default: begin
        next_state  = ST_IDLE;
        next_remain = DITC_READ_RST;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state  <= ST_IDLE;
      remain <= DITC_READ_RST;
    end else begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  // Acquisition strobes and power hold. The power hold follows the
  // mode settings one cycle late, which is harmless for a level.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acq_store       <= 1'b0;
      low_power_block <= 1'b0;
    end else begin
      acq_store       <= scan_end; // see R7
      low_power_block <= |enabled; // see R9
    end
  end

  // Handshake outputs straight from state: acq_start and acq_trig are
  // one cycle wide per scan, trig_busy covers the whole burst so the
  // logger can hold off its own interval scans if it wishes
  assign acq_start = state == ST_RUN; // see R8
  assign acq_trig  = acq_start; // see R6
  assign trig_busy = state != ST_IDLE;

endmodule // ditc_top
